/* File: rtl/sbp_status_protect.sv */
/*
  Status register, write-enable latch, busy flag and block protection
  decode of a serial NOR flash, driven through SPI mode 0 commands.
  Assumes the serial pins are asynchronous to sys_clk and that the link
  clock is at most a quarter of sys_clk so every edge is seen.
*/
module sbp_status_protect #(
  parameter int unsigned WRSR_CNT  = sbp_pkg::WRSR_CYCLES,
  parameter int unsigned PROG_CNT  = sbp_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_CNT = sbp_pkg::ERASE_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       spiCsB,
  input  wire logic       spiSck,
  input  wire logic       spiDin,
  input  wire logic       writeProtB,
  output logic            spiDout,
  output logic            spiDoutEnB,
  output logic [7:0]      statusByte,
  output logic            protErr
);

  localparam int unsigned CW = 16;

  typedef enum logic [2:0] {
    S_IDLE,
    S_CMD,
    S_ADDR,
    S_DATA,
    S_READ,
    S_DONE
  } sbp_state_t;

  // Three-stage pin synchronisers; the first stage feeds only the second
  sbp_pkg::sbp_pins_t pinS1_q, pinS2_q, pinS3_q;
  sbp_pkg::sbp_pins_t pinRaw;
  assign pinRaw = '{csB: spiCsB, sck: spiSck, din: spiDin, wpB: writeProtB};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinS1_q <= '{csB: 1'b1, sck: 1'b0, din: 1'b0, wpB: 1'b0};
      pinS2_q <= '{csB: 1'b1, sck: 1'b0, din: 1'b0, wpB: 1'b0};
      pinS3_q <= '{csB: 1'b1, sck: 1'b0, din: 1'b0, wpB: 1'b0};
    end else begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
    end
  end

  // Filtered levels: a change counts once stage two and three agree
  logic csB_q, sck_q, wpB_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      csB_q <= 1'b1;
      sck_q <= 1'b0;
      wpB_q <= 1'b0;
    end else begin
      if (pinS2_q.csB == pinS3_q.csB) csB_q <= pinS3_q.csB;
      if (pinS2_q.sck == pinS3_q.sck) sck_q <= pinS3_q.sck;
      if (pinS2_q.wpB == pinS3_q.wpB) wpB_q <= pinS3_q.wpB;
    end
  end

  wire sckNext  = (pinS2_q.sck == pinS3_q.sck) ? pinS3_q.sck : sck_q;
  wire csNext   = (pinS2_q.csB == pinS3_q.csB) ? pinS3_q.csB : csB_q;
  wire sckRise  = !sck_q && sckNext && !csB_q;
  wire sckFall  = sck_q && !sckNext && !csB_q;
  wire frameEnd = !csB_q && csNext;
  wire frameBeg = csB_q && !csNext;

  // Register state
  sbp_pkg::sbp_nv_t nv_q;
  logic             wel_q;
  logic [CW-1:0]    busyCnt_q;
  logic             busy;
  assign busy = (busyCnt_q != '0);

  wire [7:0] statusNow = {nv_q.lock, nv_q.level[3], nv_q.topBot, nv_q.level[2:0],
                          wel_q, busy};
  wire [7:0] flagNow = {!busy, 7'h00};

  // Hardware lock: only the pin level or a reset can release it
  wire hwLocked = nv_q.lock && !wpB_q;

  // Protected range decode
  function automatic logic sectProt(input sbp_pkg::sbp_nv_t nv,
                                    input logic [sbp_pkg::SECT_W-1:0] sect);
    logic [sbp_pkg::SECT_W:0] span;
    span = '0;
    if (nv.level == 4'h0) begin
      sectProt = 1'b0;
    end else if (nv.level >= 4'(sbp_pkg::LVL_ALL)) begin
      sectProt = 1'b1;
    end else begin
      span = (sbp_pkg::SECT_W+1)'(1) << (nv.level - 4'h1);
      if (nv.topBot)
        sectProt = ({1'b0, sect} < span);
      else
        sectProt = ({1'b0, sect} >= (10'(sbp_pkg::SECT_COUNT) - span));
    end
  endfunction : sectProt

  // Serial engine
  sbp_state_t           st_q;
  logic [7:0]           cmd_q;
  logic [7:0]           shIn_q;
  logic [2:0]           bitCnt_q;
  logic [1:0]           addrBytes_q;
  logic [23:0]          addr_q;
  logic [7:0]           wrData_q;
  logic                 gotData_q;
  logic [7:0]           shOut_q;

  wire [7:0] byteIn  = {shIn_q[6:0], pinS3_q.din};
  wire       byteDone = sckRise && (bitCnt_q == 3'h7);

  wire isAddrCmd = (cmd_q == sbp_pkg::CMD_PAGE_PROG) || (cmd_q == sbp_pkg::CMD_SECT_ERASE) ||
                   (cmd_q == sbp_pkg::CMD_SUB4_ERASE) || (cmd_q == sbp_pkg::CMD_SUB32_ERASE);
  // Three address bytes only, so the sector field's top bit stays zero
  wire [sbp_pkg::ADDR_W-1:0] fullAddr = {1'b0, addr_q};
  wire addrProt = sectProt(nv_q, fullAddr[sbp_pkg::SECT_LSB +: sbp_pkg::SECT_W]);

  // Frame-end decisions
  wire doWrsr  = (cmd_q == sbp_pkg::CMD_WR_STATUS) && gotData_q && wel_q && !busy
                 && !hwLocked;
  wire rejWrsr = (cmd_q == sbp_pkg::CMD_WR_STATUS) && gotData_q && wel_q && !busy && hwLocked;
  wire doBulk  = (cmd_q == sbp_pkg::CMD_BULK_ERASE) && wel_q && !busy
                 && (nv_q.level == 4'h0);
  wire rejBulk = (cmd_q == sbp_pkg::CMD_BULK_ERASE) && wel_q && !busy && (nv_q.level != 4'h0);
  wire addrOk  = isAddrCmd && (st_q != S_ADDR) && wel_q && !busy;
  wire doArr   = addrOk && !addrProt;
  wire rejArr  = addrOk && addrProt;
  wire isProg  = (cmd_q == sbp_pkg::CMD_PAGE_PROG);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q        <= S_IDLE;
      cmd_q       <= 8'h00;
      shIn_q      <= 8'h00;
      bitCnt_q    <= 3'h0;
      addrBytes_q <= 2'h0;
      addr_q      <= 24'h000000;
      wrData_q    <= 8'h00;
      gotData_q   <= 1'b0;
      shOut_q     <= 8'h00;
    end else if (frameBeg) begin
      st_q      <= S_CMD;
      bitCnt_q  <= 3'h0;
      gotData_q <= 1'b0;
      addrBytes_q <= 2'h0;
    end else if (frameEnd) begin
      st_q <= S_IDLE;
    end else if (sckRise) begin
      shIn_q   <= byteIn;
      bitCnt_q <= bitCnt_q + 3'h1;
      if (byteDone) begin
        unique case (st_q)
          S_CMD: begin
            cmd_q <= byteIn;
            if (byteIn == sbp_pkg::CMD_RD_STATUS || byteIn == sbp_pkg::CMD_RD_FLAG)
              st_q <= S_READ;
            else if (byteIn == sbp_pkg::CMD_WR_STATUS)
              st_q <= S_DATA;
            else if (byteIn == sbp_pkg::CMD_PAGE_PROG || byteIn == sbp_pkg::CMD_SECT_ERASE ||
                     byteIn == sbp_pkg::CMD_SUB4_ERASE || byteIn == sbp_pkg::CMD_SUB32_ERASE)
              st_q <= S_ADDR;
            else
              st_q <= S_DONE;
          end
          S_ADDR: begin
            addr_q      <= {addr_q[15:0], byteIn};
            addrBytes_q <= addrBytes_q + 2'h1;
            if (addrBytes_q == 2'h2) st_q <= S_DONE;
          end
          S_DATA: begin
            wrData_q  <= byteIn;
            gotData_q <= 1'b1;
            st_q      <= S_DONE;
          end
          S_READ, S_DONE, S_IDLE: ;
        endcase
      end
    end else if (sckFall && st_q == S_READ) begin
      // Register re-sampled each byte so busy polling tracks live state
      if (bitCnt_q == 3'h0)
        shOut_q <= (cmd_q == sbp_pkg::CMD_RD_FLAG) ? flagNow : statusNow;
      else
        shOut_q <= {shOut_q[6:0], 1'b0};
    end
  end

  // Nonvolatile bits, latch and busy timer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      nv_q      <= '{lock: sbp_pkg::NV_LOCK_RST, topBot: sbp_pkg::NV_TB_RST,
                     level: sbp_pkg::NV_LVL_RST};
      wel_q     <= 1'b0;
      busyCnt_q <= '0;
      protErr   <= 1'b0;
    end else begin
      if (busyCnt_q == CW'(1))
        wel_q <= 1'b0;
      if (busyCnt_q != '0)
        busyCnt_q <= busyCnt_q - CW'(1);
      if (frameEnd && st_q == S_DONE) begin
        if (cmd_q == sbp_pkg::CMD_WR_ENABLE && !busy)
          wel_q <= 1'b1;
        else if (cmd_q == sbp_pkg::CMD_WR_DISABLE && !busy)
          wel_q <= 1'b0;
        if (doWrsr) begin
          nv_q.lock   <= wrData_q[sbp_pkg::ST_LOCK_BIT];
          nv_q.topBot <= wrData_q[sbp_pkg::ST_TB_BIT];
          nv_q.level  <= {wrData_q[sbp_pkg::ST_LVL3_BIT], wrData_q[4:2]};
          busyCnt_q   <= CW'(WRSR_CNT);
        end else if (doBulk || doArr) begin
          busyCnt_q <= isProg ? CW'(PROG_CNT) : CW'(ERASE_CNT);
        end
        // Refused writes drop the latch so a stray retry needs a new enable
        if (rejWrsr || rejBulk || rejArr) begin
          wel_q   <= 1'b0;
          protErr <= 1'b1;
        end else if (doWrsr || doBulk || doArr) begin
          protErr <= 1'b0;
        end
      end
    end
  end

  // Output drive registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      spiDout    <= 1'b0;
      spiDoutEnB <= 1'b1;
      statusByte <= 8'h00;
    end else begin
      spiDout    <= (bitCnt_q == 3'h0 && sckFall) ? 1'b0 : shOut_q[7];
      spiDoutEnB <= !(st_q == S_READ && !csB_q);
      statusByte <= statusNow;
    end
  end

endmodule : sbp_status_protect

/* File: include/sbp_pkg.sv */
/*
  Constants and types for the status register and block-protection logic.
  Assumes a single 20 MHz system clock; the serial link clock is sampled as data.
*/
package sbp_pkg;

  // Serial commands handled by this block
  localparam logic [7:0] CMD_WR_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
  localparam logic [7:0] CMD_RD_STATUS  = 8'h05;
  localparam logic [7:0] CMD_WR_STATUS  = 8'h01;
  localparam logic [7:0] CMD_RD_FLAG    = 8'h70;
  localparam logic [7:0] CMD_PAGE_PROG  = 8'h02;
  localparam logic [7:0] CMD_SECT_ERASE = 8'hd8;
  localparam logic [7:0] CMD_SUB4_ERASE = 8'h20;
  localparam logic [7:0] CMD_SUB32_ERASE = 8'h52;
  localparam logic [7:0] CMD_BULK_ERASE = 8'hc7;

  // Status register field positions
  localparam int unsigned ST_LOCK_BIT = 7;
  localparam int unsigned ST_LVL3_BIT = 6;
  localparam int unsigned ST_TB_BIT   = 5;
  localparam int unsigned ST_WEL_BIT  = 1;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned FLAG_RDY_BIT = 7;

  // Array geometry
  localparam int unsigned ADDR_W       = 25;
  localparam int unsigned SECT_W       = 9;
  localparam int unsigned SECT_LSB     = 16;
  localparam int unsigned SECT_COUNT   = 512;
  localparam int unsigned SUB32_COUNT  = 1024;
  localparam int unsigned SUB4_COUNT   = 8192;
  localparam int unsigned LVL_ALL      = 10;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 25'h1ffffff;

  // Nonvolatile defaults
  localparam logic       NV_LOCK_RST = 1'b0;
  localparam logic       NV_TB_RST   = 1'b0;
  localparam logic [3:0] NV_LVL_RST  = 4'h0;

  // Internal cycle times
  localparam int unsigned CLK_MHZ          = 20;
  localparam int unsigned T_WRSR_US        = 8;
  localparam int unsigned T_PROG_US        = 120;
  localparam int unsigned T_ERASE_US       = 150;
  localparam int unsigned WRSR_CYCLES  = T_WRSR_US * CLK_MHZ;
  localparam int unsigned PROG_CYCLES  = T_PROG_US * CLK_MHZ;
  localparam int unsigned ERASE_CYCLES = T_ERASE_US * CLK_MHZ;

  typedef struct packed {
    logic       lock;
    logic       topBot;
    logic [3:0] level;
  } sbp_nv_t;

  typedef struct packed {
    logic csB;
    logic sck;
    logic din;
    logic wpB;
  } sbp_pins_t;

endpackage : sbp_pkg

/* File: dv/sbp_status_protect_sva.sv */
/* Concurrent checks on the status and block-protection block.
   Assumes binding to the top module with the same cycle-count parameters. */
module sbp_status_protect_sva #(
  parameter int unsigned WRSR_CNT  = 12,
  parameter int unsigned PROG_CNT  = 14,
  parameter int unsigned ERASE_CNT = 300
) (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       spiCsB,
  input wire logic       writeProtB,
  input wire logic       spiDoutEnB,
  input wire logic [7:0] statusByte,
  input wire logic       protErr
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LO1 = WRSR_CNT < PROG_CNT ? WRSR_CNT : PROG_CNT;
  localparam int LO  = LO1 < ERASE_CNT ? LO1 : ERASE_CNT;
  localparam int HI1 = WRSR_CNT > PROG_CNT ? WRSR_CNT : PROG_CNT;
  // Slack of two for the delayed status copy
  localparam int HI  = (HI1 > ERASE_CNT ? HI1 : ERASE_CNT) + 2;
  logic [15:0] busyCnt_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) busyCnt_q <= 16'h0000;
    else busyCnt_q <= statusByte[0] ? busyCnt_q + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_reset_clear: assert property ($rose(rst_b) |-> statusByte == 8'h00 && !protErr)
    else $error("status not clear after reset");
  a_lock_holds: assert property ((statusByte[7] && !writeProtB && !statusByte[0])[*6]
    |=> $stable(statusByte[7:2])) else $error("locked status changed");
  a_idle_released: assert property (spiCsB[*6] |-> spiDoutEnB)
    else $error("output driven while deselected");
  a_busy_needs_wel: assert property ($rose(statusByte[0]) |-> statusByte[1])
    else $error("cycle started without write enable");
  a_busy_end_wel: assert property ($fell(statusByte[0]) |-> !statusByte[1])
    else $error("write enable kept after cycle");
  a_busy_len_min: assert property ($fell(statusByte[0]) |-> busyCnt_q >= LO)
    else $error("busy too short");
  a_busy_len_max: assert property (statusByte[0] |-> busyCnt_q < HI)
    else $error("busy too long");
  a_refuse_wel: assert property ($rose(protErr) |-> !statusByte[0] ##[0:2] !statusByte[1])
    else $error("refusal left write enable or busy");
  a_busy_no_wren: assert property (statusByte[0] |-> !$rose(statusByte[1]))
    else $error("write enable set while busy");
endmodule : sbp_status_protect_sva
bind sbp_status_protect sbp_status_protect_sva #(.WRSR_CNT(WRSR_CNT), .PROG_CNT(PROG_CNT),
  .ERASE_CNT(ERASE_CNT)) sbp_status_protect_sva_inst (.sys_clk(sys_clk), .rst_b(rst_b),
  .spiCsB(spiCsB), .writeProtB(writeProtB), .spiDoutEnB(spiDoutEnB),
  .statusByte(statusByte), .protErr(protErr));

/* File: dv/sbp_spi_host.sv */
/* Serial host model, mode 0, one frame per call of xfer.
   Assumes the caller enters xfer just after a rising sys_clk edge. */
module sbp_spi_host (
  input  wire logic sys_clk,
  input  wire logic spiDout,
  output logic      spiCsB,
  output logic      spiSck,
  output logic      spiDin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    spiCsB = 1'b1;
    spiSck = 1'b0;
    spiDin = 1'b0;
  end
  // Link clock runs at 8 sys_clk a period, stands low between frames
  task automatic xfer(input logic [7:0] b [$], output logic [7:0] rd);
    spiCsB <= 1'b0;
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k--) begin
        spiDin <= b[i][k];
        repeat (4) @(posedge sys_clk);
        spiSck <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd[k] = spiDout;
        spiSck <= 1'b0;
      end
    end
    repeat (4) @(posedge sys_clk);
    spiCsB <= 1'b1;
    spiDin <= ~spiDin; // Released line must not look held
    repeat (8) @(posedge sys_clk);
  endtask : xfer
endmodule : sbp_spi_host

/* File: dv/test_status_reg_block_protect.sv */
/* Self-checking bench for the status and block-protection block.
   Assumes the host model and the bound checker beside it. */
module test_status_reg_block_protect;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk, rst_b, writeProtB, spiCsB, spiSck, spiDin, spiDout, spiDoutEnB, protErr;
  logic [7:0] statusByte, rd, st;
  int         errors, checkCount;
  // Row: bottom anchor, level, sector, refused
  logic [13:0] rowTab [13] = '{{1'b0, 4'h0, 8'hff, 1'b0}, {1'b0, 4'h9, 8'hff, 1'b0},
    {1'b0, 4'ha, 8'h00, 1'b1}, {1'b0, 4'hf, 8'h7f, 1'b1}, {1'b1, 4'h0, 8'h00, 1'b0},
    {1'b1, 4'h1, 8'h00, 1'b1}, {1'b1, 4'h1, 8'h01, 1'b0}, {1'b1, 4'h5, 8'h0f, 1'b1},
    {1'b1, 4'h5, 8'h10, 1'b0}, {1'b1, 4'h9, 8'hff, 1'b1}, {1'b1, 4'h8, 8'h7f, 1'b1},
    {1'b1, 4'h8, 8'h80, 1'b0}, {1'b1, 4'hc, 8'hff, 1'b1}};
  // Long erase so a flag read fits inside it
  sbp_status_protect #(.WRSR_CNT(12), .PROG_CNT(14), .ERASE_CNT(300)) sbp_status_protect_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .spiCsB(spiCsB), .spiSck(spiSck), .spiDin(spiDin),
    .writeProtB(writeProtB), .spiDout(spiDout), .spiDoutEnB(spiDoutEnB),
    .statusByte(statusByte), .protErr(protErr));
  sbp_spi_host sbp_spi_host_inst (.sys_clk(sys_clk), .spiDout(spiDout), .spiCsB(spiCsB),
    .spiSck(spiSck), .spiDin(spiDin));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cmd(input logic [7:0] b [$]);
    sbp_spi_host_inst.xfer(b, rd);
  endtask : cmd
  task automatic wcmd(input logic [7:0] b [$]);
    cmd('{sbp_pkg::CMD_WR_ENABLE});
    cmd(b);
  endtask : wcmd
  task automatic idle();
    for (int i = 0; i < 400 && statusByte[0] !== 1'b0; i++)
      @(posedge sys_clk);
  endtask : idle
  task automatic wrst(input logic [7:0] v);
    wcmd('{sbp_pkg::CMD_WR_STATUS, v});
    idle();
  endtask : wrst
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (80000) @(posedge sys_clk);
    errors++;
    give_verdict();
  end
  initial begin
    rst_b = 1'b0;
    writeProtB = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    check("reset", statusByte, 8'h00);
    foreach (rowTab[r]) begin
      st = {1'b0, rowTab[r][12], rowTab[r][13], rowTab[r][11:9], 2'b00};
      wrst(st);
      cmd('{sbp_pkg::CMD_RD_STATUS, 8'h00});
      check("status", rd, st);
      wcmd('{sbp_pkg::CMD_SECT_ERASE, rowTab[r][8:1], 8'h00, 8'h00});
      idle();
      check("refused", {7'h00, protErr}, {7'h00, rowTab[r][0]});
      check("wel", statusByte & 8'h02, 8'h00);
    end
    wcmd('{sbp_pkg::CMD_BULK_ERASE});
    check("bulk refused", {6'h00, protErr, statusByte[0]}, 8'h02);
    wrst(8'h00);
    wcmd('{sbp_pkg::CMD_BULK_ERASE});
    cmd('{sbp_pkg::CMD_RD_FLAG, 8'h00});
    check("flag busy", rd & 8'h80, 8'h00);
    check("busy", statusByte & 8'h03, 8'h03);
    idle();
    cmd('{sbp_pkg::CMD_RD_FLAG, 8'h00});
    check("flag ready", rd & 8'h80, 8'h80);
    check("bulk ran", {7'h00, protErr}, 8'h00);
    wrst(8'h24);
    wcmd('{sbp_pkg::CMD_PAGE_PROG, 8'h00, 8'h00, 8'h00, 8'h5a});
    check("prog", {7'h00, protErr}, 8'h01);
    wcmd('{sbp_pkg::CMD_SUB4_ERASE, 8'h01, 8'h00, 8'h00});
    idle();
    check("sub4", {7'h00, protErr}, 8'h00);
    wcmd('{sbp_pkg::CMD_SUB32_ERASE, 8'h00, 8'h80, 8'h00});
    check("sub32", {7'h00, protErr}, 8'h01);
    wrst(8'h80);
    check("lock set", statusByte, 8'h80);
    writeProtB <= 1'b0;
    wrst(8'h00);
    check("locked", statusByte, 8'h80);
    check("lock err", {7'h00, protErr}, 8'h01);
    writeProtB <= 1'b1;
    wrst(8'h00);
    check("unlocked", statusByte, 8'h00);
    cmd('{sbp_pkg::CMD_WR_STATUS, 8'h1c});
    check("no wel", statusByte, 8'h00);
    cmd('{sbp_pkg::CMD_WR_ENABLE});
    check("wel set", statusByte, 8'h02);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    check("mid reset", {statusByte[7:1], spiDoutEnB}, 8'h01);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    give_verdict();
  end
endmodule : test_status_reg_block_protect
